// File: bench/port_masters.sv
// port master model: pin clocks, controls and the two-way port a data
`timescale 1ns/10ps
`default_nettype none
module port_masters #(
	parameter int DW = 36
) (
	input  wire logic          i_clk,    // core clock
	input  wire logic [DW-1:0] i_dev_a,  // device data on port a
	input  wire logic          i_oe_n,   // low while device drives
	input  wire logic          i_rdy,    // fifo1 input ready
	output logic               o_a_clk,  // port a clock
	output logic               o_b_clk,  // port b clock
	output logic               o_c_clk,  // port c clock
	output logic               o_a_cs_n, // port a select
	output logic               o_a_dir,  // port a direction
	output logic               o_a_en,   // port a enable
	output logic               o_b_cs_n, // port b select
	output logic               o_b_ren,  // port b read enable
	output logic               o_c_wen,  // port c write enable
	output logic [DW-1:0]      o_a_wire, // resolved port a level
	output logic [DW-1:0]      o_c_data  // port c data
);
	logic [DW-1:0] a_drv = '0;
	// the device wins the wire while its enable is low
	assign o_a_wire = i_oe_n ? a_drv : i_dev_a;
	// idle pins at time zero
	initial
	begin
		{o_a_clk, o_b_clk, o_c_clk, o_a_cs_n, o_a_dir, o_a_en} = 6'h04;
		{o_b_cs_n, o_b_ren, o_c_wen} = 3'h4;
		o_c_data = '0;
	end
	// one port cycle: controls lead the clock rise by 2 cycles and hold well past it
	task step(input logic [2:0] clks, input logic a_cs_n, a_dir, a_en, b_cs_n, c_wen, input logic [DW-1:0] dat);
		@(posedge i_clk);
		#1;
		o_a_cs_n = a_cs_n;
		o_a_dir = a_dir;
		o_a_en = a_en;
		o_b_cs_n = b_cs_n;
		o_b_ren = !b_cs_n;
		o_c_wen = c_wen;
		a_drv = (!a_cs_n && a_dir) ? dat : ~a_drv;
		o_c_data = c_wen ? dat : ~o_c_data;
		repeat (2) @(posedge i_clk);
		#1;
		{o_c_clk, o_b_clk, o_a_clk} = clks;
		repeat (3) @(posedge i_clk);
		#1;
		{o_c_clk, o_b_clk, o_a_clk} = 3'h0;
		repeat (2) @(posedge i_clk);
		#1;
	endtask : step
	// fifo1 write, offered only while input ready is high
	task a_write(input logic [DW-1:0] dat);
		if (i_rdy)
			step(3'h1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, dat);
	endtask : a_write
endmodule : port_masters
`default_nettype wire

// File: bench/tb_top.sv
// self-checking bench for the dual fifo flag and loopback block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	localparam int DEPTH = 16;
	localparam int DW    = 36;
	localparam int OW    = $clog2(DEPTH);
	logic          clk = 1'b0, rst = 1'b1, first_word_fall_through = 1'b0, loop_n = 1'b1, ld = 1'b0;
	logic [OW-1:0] x1, y1, x2, y2;
	logic          a_clk, b_clk, c_clk, a_cs_n, a_dir, a_en, b_cs_n, b_ren, c_wen, oe_n;
	logic          f1_ff, f1_af_n, f2_ef, f2_ae_n, f1_ef, f1_ae_n, f2_ff, f2_af_n;
	logic [DW-1:0] a_wire, c_data, a_dout, b_dout, w, a_exp = '0, b_exp = '0;
	logic [DW-1:0] q1[$], q2[$];
	logic [31:0]   lfsr = 32'hD9BF6A54;
	int            bad_count = 0, checked = 0;
	always #20 clk = ~clk;
	// device under test, small depth
	dual_fifo_flags_loopback #(.DEPTH(DEPTH), .DATA_W(DW)) u_dual_fifo_flags_loopback (
		.i_clk(clk), .i_sys_rst(rst), .i_port_a_clock(a_clk), .i_port_b_clock(b_clk), .i_port_c_clock(c_clk),
		.i_port_a_chip_select_n(a_cs_n), .i_port_a_direction(a_dir), .i_port_a_enable(a_en),
		.i_port_a_mailbox_select(1'b0), .i_loop_select_n(loop_n), .i_port_a_data(a_wire),
		.o_port_a_data(a_dout), .o_port_a_data_oe_n(oe_n), .i_port_b_chip_select_n(b_cs_n),
		.i_port_b_read_enable(b_ren), .i_port_b_mailbox_select(1'b0), .o_port_b_data(b_dout),
		.i_port_c_write_enable(c_wen), .i_port_c_mailbox_select(1'b0), .i_port_c_data(c_data),
		.i_first_word_fall_through(first_word_fall_through), .i_offset_load(ld), .i_fifo1_empty_offset(x1),
		.i_fifo1_full_offset(y1), .i_fifo2_empty_offset(x2), .i_fifo2_full_offset(y2),
		.o_fifo1_full_or_in_ready(f1_ff), .o_fifo1_almost_full_n(f1_af_n), .o_fifo2_empty_or_out_ready(f2_ef),
		.o_fifo2_almost_empty_n(f2_ae_n), .o_fifo1_empty_or_out_ready(f1_ef), .o_fifo1_almost_empty_n(f1_ae_n),
		.o_fifo2_full_or_in_ready(f2_ff), .o_fifo2_almost_full_n(f2_af_n));
	// masters on the three ports
	port_masters #(.DW(DW)) u_port_masters (.i_clk(clk), .i_dev_a(a_dout), .i_oe_n(oe_n), .i_rdy(f1_ff),
		.o_a_clk(a_clk), .o_b_clk(b_clk), .o_c_clk(c_clk), .o_a_cs_n(a_cs_n), .o_a_dir(a_dir), .o_a_en(a_en),
		.o_b_cs_n(b_cs_n), .o_b_ren(b_ren), .o_c_wen(c_wen), .o_a_wire(a_wire), .o_c_data(c_data));
	// galois shift register, one new word per call
	function automatic logic [DW-1:0] new_word();
		lfsr = {1'b0, lfsr[31:1]} ^ (lfsr[0] ? 32'h80200003 : 32'h0);
		return {lfsr[7:4], lfsr};
	endfunction : new_word
	// expected empty, almost-empty_n, full, almost-full_n for a memory count
	function automatic logic [3:0] exp_flags(input int cnt, input logic [OW-1:0] x, y);
		return {cnt != 0, cnt > int'(x), cnt != DEPTH, cnt < DEPTH - int'(y)};
	endfunction : exp_flags
	task check(input string what, input logic [DW-1:0] exp, got);
		checked++;
		if (got !== exp)
		begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	task results();
		if (bad_count == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : results
	task new_offsets();
		w = new_word();
		x1 = OW'(1 + w[7:0] % 6);
		y1 = OW'(1 + w[15:8] % 6);
		x2 = OW'(1 + w[23:16] % 6);
		y2 = OW'(1 + w[31:24] % 6);
	endtask : new_offsets
	// idle cycles on all ports let the flags catch up, then compare them
	task settle();
		repeat (3) u_port_masters.step(3'h7, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, new_word());
		check("fifo1 flags", exp_flags(q1.size(), x1, y1), {f1_ef, f1_ae_n, f1_ff, f1_af_n});
		check("fifo2 flags", exp_flags(q2.size(), x2, y2), {f2_ef, f2_ae_n, f2_ff, f2_af_n});
	endtask : settle
	task b_read();
		u_port_masters.step(3'h2, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, new_word());
		if (q1.size() > 0)
			b_exp = q1.pop_front();
		check("port b data", b_exp, b_dout);
		settle();
	endtask : b_read
	task c_write();
		w = new_word();
		u_port_masters.step(3'h4, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, w);
		if (q2.size() < DEPTH)
			q2.push_back(w);
		settle();
	endtask : c_write
	// port a edge: plain read with loopback off, loop transfer with it on
	task a_edge(input logic dir);
		logic full;
		full = q1.size() >= DEPTH;
		u_port_masters.step(3'h1, 1'b0, dir, 1'b1, 1'b1, 1'b0, new_word());
		if (!loop_n && !full)
			q1.push_back(a_exp);
		if (q2.size() > 0 && (loop_n || !full || !dir))
			a_exp = q2.pop_front();
		check("port a oe_n", dir, oe_n);
		if (!dir)
			check("port a data", a_exp, a_dout);
		settle();
	endtask : a_edge
	// hang guard
	initial
	begin
		repeat (20000) @(posedge clk);
		bad_count++;
		results();
	end
	// main sequence
	initial
	begin
		new_offsets();
		repeat (3) @(posedge clk);
		#1;
		rst = 1'b0;
		check("port a oe_n", 1'b1, oe_n);
		for (int i = 0; i <= DEPTH; i++)
		begin
			if (i == DEPTH / 2)
			begin
				new_offsets();
				@(posedge clk);
				#1;
				ld = 1'b1;
				@(posedge clk);
				#1;
				ld = 1'b0;
			end
			w = new_word();
			if (i < DEPTH)
				u_port_masters.a_write(w);
			else
				u_port_masters.step(3'h1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, w);
			if (q1.size() < DEPTH)
				q1.push_back(w);
			settle();
		end
		for (int i = 0; i <= DEPTH; i++)
			b_read();
		for (int i = 0; i <= DEPTH; i++)
			c_write();
		repeat (10) a_edge(1'b0);
		@(posedge clk);
		#1;
		loop_n = 1'b0;
		repeat (10) a_edge(1'b1);
		repeat (4) a_edge(1'b0);
		repeat (6) c_write();
		repeat (5) a_edge(1'b0);
		a_edge(1'b1);
		a_edge(1'b0);
		@(posedge clk);
		#1;
		loop_n = 1'b1;
		repeat (DEPTH) b_read();
		rst = 1'b1;
		first_word_fall_through = 1'b1;
		repeat (3) @(posedge clk);
		#1;
		rst = 1'b0;
		w = new_word();
		u_port_masters.a_write(w);
		for (int i = 1; i <= 3; i++)
		begin
			u_port_masters.step(3'h2, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, new_word());
			check("fifo1 out ready", i == 3, f1_ef);
		end
		check("port b data", w, b_dout);
		check("fifo1 almost empty", 1'b0, f1_ae_n);
		b_exp = new_word();
		u_port_masters.a_write(b_exp);
		repeat (3) u_port_masters.step(3'h2, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, new_word());
		check("port b data", w, b_dout);
		for (int i = 0; i < 3; i++)
		begin
			u_port_masters.step(3'h2, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, new_word());
			check("port b data", b_exp, b_dout);
			check("fifo1 out ready", i == 0, f1_ef);
		end
		results();
	end
endmodule : tb_top
`default_nettype wire

// File: logic/dual_fifo_flags_loopback.sv
// two fifos with re-timed status flags and port a loopback
`timescale 1ns/10ps
`default_nettype none
`include "fifo_flags_map.svh"
module dual_fifo_flags_loopback #(
	parameter int DEPTH     = `DEPTH_DEF,
	parameter int DATA_W    = `DATA_W_DEF,
	parameter int BUF_DEPTH = `BUF_DEPTH_DEF
) (
	input  wire logic                      i_clk,                      // core clock, 25 MHz
	input  wire logic                      i_sys_rst,                  // sync reset, high
	input  wire logic                      i_port_a_clock,             // port a clock pin
	input  wire logic                      i_port_b_clock,             // port b clock pin
	input  wire logic                      i_port_c_clock,             // port c clock pin
	input  wire logic                      i_port_a_chip_select_n,     // port a select, low
	input  wire logic                      i_port_a_direction,         // high write, low read
	input  wire logic                      i_port_a_enable,            // port a enable
	input  wire logic                      i_port_a_mailbox_select,    // high picks mail path
	input  wire logic                      i_loop_select_n,            // low enables loopback
	input  wire logic [DATA_W-1:0]         i_port_a_data,              // port a data in
	output logic      [DATA_W-1:0]         o_port_a_data,              // port a data out
	output logic                           o_port_a_data_oe_n,         // low while driving
	input  wire logic                      i_port_b_chip_select_n,     // port b select, low
	input  wire logic                      i_port_b_read_enable,       // port b read enable
	input  wire logic                      i_port_b_mailbox_select,    // high picks mail path
	output logic      [DATA_W-1:0]         o_port_b_data,              // fifo1 output word
	input  wire logic                      i_port_c_write_enable,      // port c write enable
	input  wire logic                      i_port_c_mailbox_select,    // high picks mail path
	input  wire logic [DATA_W-1:0]         i_port_c_data,              // port c data in
	input  wire logic                      i_first_word_fall_through,  // high first_word_fall_through, low standard
	input  wire logic                      i_offset_load,              // loads offset ports
	input  wire logic [$clog2(DEPTH)-1:0]  i_fifo1_empty_offset,       // fifo1 almost-empty offset
	input  wire logic [$clog2(DEPTH)-1:0]  i_fifo1_full_offset,        // fifo1 almost-full offset
	input  wire logic [$clog2(DEPTH)-1:0]  i_fifo2_empty_offset,       // fifo2 almost-empty offset
	input  wire logic [$clog2(DEPTH)-1:0]  i_fifo2_full_offset,        // fifo2 almost-full offset
	output logic                           o_fifo1_full_or_in_ready,   // port a side
	output logic                           o_fifo1_almost_full_n,      // port a side
	output logic                           o_fifo2_empty_or_out_ready, // port a side
	output logic                           o_fifo2_almost_empty_n,     // port a side
	output logic                           o_fifo1_empty_or_out_ready, // port b side
	output logic                           o_fifo1_almost_empty_n,     // port b side
	output logic                           o_fifo2_full_or_in_ready,   // port c side
	output logic                           o_fifo2_almost_full_n       // port c side
);

	localparam int ADDR_W = $clog2(DEPTH);
	localparam int PTR_W  = ADDR_W + 1;
	localparam int BUF_AW = $clog2(BUF_DEPTH);
	localparam int CTL    = 2 * DATA_W;
	localparam int PIN_W  = CTL + `P_NUM;
	localparam logic [PTR_W-1:0]  FULL_CNT = PTR_W'(DEPTH);
	localparam logic [PTR_W-1:0]  PTR_ONE  = PTR_W'(1);
	localparam logic [BUF_AW:0]   BUF_FULL = (BUF_AW + 1)'(BUF_DEPTH);
	localparam logic [BUF_AW:0]   BUF_ONE  = (BUF_AW + 1)'(1);
	localparam logic [BUF_AW-1:0] BPTR_ONE = BUF_AW'(1);

	// all state of the block apart from the fifo memory
	typedef struct packed {
		logic [PIN_W-1:0]                 s1;
		logic [PIN_W-1:0]                 s2;
		logic [2:0]                       clk_prev;
		logic [`NUM_FLAGS-1:0]            st1;
		logic [`NUM_FLAGS-1:0]            st2;
		logic [1:0][PTR_W-1:0]            wr;
		logic [1:0][PTR_W-1:0]            rd;
		logic [1:0][DATA_W-1:0]           outr;
		logic [1:0]                       ov;
		logic [1:0][ADDR_W-1:0]           xo;
		logic [1:0][ADDR_W-1:0]           yo;
		logic [BUF_DEPTH-1:0][DATA_W-1:0] bd;
		logic [BUF_AW-1:0]                bwp;
		logic [BUF_AW-1:0]                brp;
		logic [BUF_AW:0]                  bcnt;
		logic                             a_oe_n;
	} state_t;

	state_t                       st;
	state_t                       next_st;
	logic [DATA_W-1:0]            mem [0:1][0:DEPTH-1];
	logic [2:0]                   edg;
	logic                         a_cs;
	logic                         a_dir;
	logic                         a_en;
	logic                         a_mb;
	logic                         loop;
	logic                         b_cs;
	logic                         b_ren;
	logic                         b_mb;
	logic                         c_wen;
	logic                         c_mb;
	logic                         first_word_fall_through;
	logic [DATA_W-1:0]            a_din;
	logic [DATA_W-1:0]            c_din;
	fifo_flags_pkg::port_a_mode_t mode;
	logic [1:0][PTR_W-1:0]        cnt;
	logic [`NUM_FLAGS-1:0]        raw;
	logic [`NUM_FLAGS-1:0]        em;
	logic [`NUM_FLAGS-1:0]        flag;
	logic [1:0]                   rd_edge;
	logic [1:0]                   wr_edge;
	logic [1:0]                   rdy_out;
	logic [1:0]                   rd_att;
	logic [1:0]                   rd_ok;
	logic [1:0]                   shift;
	logic [1:0]                   we;
	logic [1:0][DATA_W-1:0]       wdat;
	logic [1:0][DATA_W-1:0]       mem_q;
	logic                         f1_wok;
	logic                         buf_rdy;
	logic                         drain;
	logic                         c_acc;
	logic [PIN_W-1:0]             pins;

	// raw pin vector: controls above port c data above port a data
	assign pins = {i_port_c_mailbox_select, i_port_c_write_enable,
		i_port_b_mailbox_select, i_port_b_read_enable, i_port_b_chip_select_n,
		i_loop_select_n, i_port_a_mailbox_select, i_port_a_enable,
		i_port_a_direction, i_port_a_chip_select_n, i_port_c_clock,
		i_port_b_clock, i_port_a_clock, i_port_c_data, i_port_a_data};

	// port clock edges and control levels, taken from the second sync stage
	assign edg   = st.s2[CTL+`P_PORT_C_CLOCK:CTL+`P_PORT_A_CLOCK] & ~st.clk_prev;
	assign a_cs  = ~st.s2[CTL+`P_A_CSN];
	assign a_dir = st.s2[CTL+`P_A_DIR];
	assign a_en  = st.s2[CTL+`P_A_EN];
	assign a_mb  = st.s2[CTL+`P_A_MB];
	assign loop  = ~st.s2[CTL+`P_LOOPN];
	assign b_cs  = ~st.s2[CTL+`P_B_CSN];
	assign b_ren = st.s2[CTL+`P_B_REN];
	assign b_mb  = st.s2[CTL+`P_B_MB];
	assign c_wen = st.s2[CTL+`P_C_WEN];
	assign c_mb  = st.s2[CTL+`P_C_MB];
	assign a_din = st.s2[DATA_W-1:0];
	assign c_din = st.s2[CTL-1:DATA_W];
	assign first_word_fall_through  = i_first_word_fall_through;

	// port a manner from loop select and direction
	assign mode = !loop ? fifo_flags_pkg::PA_NORMAL :
		(a_dir ? fifo_flags_pkg::PA_LOOP_WR : fifo_flags_pkg::PA_LOOP_RD);

	// fifo1 is read by port b and written by port a; fifo2 read by a, written by c
	assign rd_edge = {edg[0], edg[1]};
	assign wr_edge = {edg[2], edg[0]};

	// per fifo: memory count, raw thresholds, stage clocks, output register
	for (genvar g = 0; g < 2; g++)
	begin : g_fifo
		assign cnt[g] = st.wr[g] - st.rd[g];
		assign raw[`F_STRIDE*g+`F_EF] = cnt[g] != '0;
		assign raw[`F_STRIDE*g+`F_AE] = cnt[g] > {1'b0, st.xo[g]};
		assign raw[`F_STRIDE*g+`F_FF] = cnt[g] != FULL_CNT;
		assign raw[`F_STRIDE*g+`F_AF] = cnt[g] < (FULL_CNT - {1'b0, st.yo[g]});
		assign em[`F_STRIDE*g+`F_EF]  = rd_edge[g];
		assign em[`F_STRIDE*g+`F_AE]  = rd_edge[g];
		assign em[`F_STRIDE*g+`F_FF]  = wr_edge[g];
		assign em[`F_STRIDE*g+`F_AF]  = wr_edge[g];
		// first_word_fall_through shows output-register valid, standard shows the empty flag
		assign rdy_out[g] = first_word_fall_through ? st.ov[g] : flag[`F_STRIDE*g+`F_EF];
		assign mem_q[g]   = mem[g][st.rd[g][ADDR_W-1:0]];
		// first_word_fall_through loads unrequested on the edge after two stages, i.e. the third edge
		assign shift[g] = first_word_fall_through ?
			(rd_edge[g] & flag[`F_STRIDE*g+`F_EF] & (~st.ov[g] | rd_ok[g])) : rd_ok[g];
	end

	// a flag goes bad at once and good only after two clean stages
	assign flag = st.st2 & raw;

	// read attempts; ignored while the port's ready or empty flag is low
	assign rd_att[0] = edg[1] & b_cs & b_ren & ~b_mb;
	assign rd_att[1] = edg[0] & a_cs & a_en & ~a_mb & (loop ? (f1_wok | ~a_dir) : ~a_dir);
	assign rd_ok     = rd_att & rdy_out;

	// fifo1 write: port a data normally, fifo2 output word in loop
	assign f1_wok  = flag[`F_FF];
	assign we[0]   = edg[0] & a_cs & a_en & ~a_mb & f1_wok & (loop | a_dir);
	assign wdat[0] = loop ? st.outr[1] : a_din;

	// port c words queue in the buffer and drain while fifo2 has room
	assign buf_rdy = st.bcnt != BUF_FULL;
	assign c_acc   = edg[2] & c_wen & ~c_mb & flag[`F_STRIDE+`F_FF] & buf_rdy;
	assign drain   = (st.bcnt != '0) & raw[`F_STRIDE+`F_FF];
	assign we[1]   = drain;
	assign wdat[1] = st.bd[st.brp];

	// next state of the whole block
	always_comb
	begin
		next_st = st;
		next_st.s1 = pins;
		next_st.s2 = st.s1;
		next_st.clk_prev = st.s2[CTL+`P_PORT_C_CLOCK:CTL+`P_PORT_A_CLOCK];
		// stages advance on their own port edge and clear when the level drops
		next_st.st1 = (em & raw) | (~em & st.st1 & raw);
		next_st.st2 = (em & st.st1 & raw) | (~em & st.st2 & raw);
		for (int g = 0; g < 2; g++)
		begin
			if (we[g])
			begin
				next_st.wr[g] = st.wr[g] + PTR_ONE;
			end
			if (shift[g])
			begin
				next_st.rd[g]   = st.rd[g] + PTR_ONE;
				next_st.outr[g] = mem_q[g];
			end
			next_st.ov[g] = first_word_fall_through & (shift[g] | (st.ov[g] & ~rd_ok[g]));
		end
		// two-entry port c buffer
		if (c_acc)
		begin
			next_st.bd[st.bwp] = c_din;
			next_st.bwp = st.bwp + BPTR_ONE;
		end
		if (drain)
		begin
			next_st.brp = st.brp + BPTR_ONE;
		end
		case ({c_acc, drain})
			2'h2:    next_st.bcnt = st.bcnt + BUF_ONE;
			2'h1:    next_st.bcnt = st.bcnt - BUF_ONE;
			default: next_st.bcnt = st.bcnt;
		endcase
		// offset programming strobe
		if (i_offset_load)
		begin
			next_st.xo = {i_fifo2_empty_offset, i_fifo1_empty_offset};
			next_st.yo = {i_fifo2_full_offset, i_fifo1_full_offset};
		end
		// port a output drive
		case (mode)
			fifo_flags_pkg::PA_NORMAL:  next_st.a_oe_n = ~(a_cs & ~a_dir);
			fifo_flags_pkg::PA_LOOP_WR: next_st.a_oe_n = 1'b1;
			fifo_flags_pkg::PA_LOOP_RD: next_st.a_oe_n = ~a_cs;
			default:                    next_st.a_oe_n = 1'b1;
		endcase
		// reset empties both fifos and takes the offsets from the ports
		if (i_sys_rst)
		begin
			next_st        = '0;
			// pin syncs keep running, so zeroed stages never read as a select or loop
			next_st.s1       = pins;
			next_st.s2       = st.s1;
			next_st.clk_prev = st.s2[CTL+`P_PORT_C_CLOCK:CTL+`P_PORT_A_CLOCK];
			next_st.st1    = `FLAG_RST;
			next_st.st2    = `FLAG_RST;
			next_st.a_oe_n = 1'b1;
			next_st.xo     = {i_fifo2_empty_offset, i_fifo1_empty_offset};
			next_st.yo     = {i_fifo2_full_offset, i_fifo1_full_offset};
		end
	end

	// state register
	always_ff @(posedge i_clk)
	begin
		st <= next_st;
	end

	// fifo storage, written at the write pointer
	always_ff @(posedge i_clk)
	begin
		for (int g = 0; g < 2; g++)
		begin
			if (we[g])
			begin
				mem[g][st.wr[g][ADDR_W-1:0]] <= wdat[g];
			end
		end
	end

	// port outputs
	assign o_port_a_data              = st.outr[1];
	assign o_port_a_data_oe_n         = st.a_oe_n;
	assign o_port_b_data              = st.outr[0];
	assign o_fifo1_full_or_in_ready   = flag[`F_FF];
	assign o_fifo1_almost_full_n      = flag[`F_AF];
	assign o_fifo2_empty_or_out_ready = rdy_out[1];
	assign o_fifo2_almost_empty_n     = flag[`F_STRIDE+`F_AE];
	assign o_fifo1_empty_or_out_ready = rdy_out[0];
	assign o_fifo1_almost_empty_n     = flag[`F_AE];
	assign o_fifo2_full_or_in_ready   = flag[`F_STRIDE+`F_FF] & buf_rdy;
	assign o_fifo2_almost_full_n      = flag[`F_STRIDE+`F_AF];

	// checks on the block's own behaviour
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_sys_rst);

	chk_loop_source: assert property (we[0] && loop |-> wdat[0] == st.outr[1])
		else $error("loop write does not carry the fifo2 output word");
	chk_loop_write_hiz: assert property (mode == fifo_flags_pkg::PA_LOOP_WR |=> o_port_a_data_oe_n)
		else $error("port a driven in loop with write direction");
	chk_loop_read_drive: assert property (mode == fifo_flags_pkg::PA_LOOP_RD && a_cs |=> !o_port_a_data_oe_n)
		else $error("port a not driven in loop with read direction");
	chk_normal_source: assert property (we[0] && !loop |-> wdat[0] == a_din)
		else $error("normal write does not take port a data");
	chk_no_overflow: assert property (we[0] |-> cnt[0] != FULL_CNT)
		else $error("fifo1 written while full");
	chk_no_underflow: assert property (shift[1] |-> cnt[1] != '0)
		else $error("fifo2 read while empty");
	chk_ae_level: assert property (o_fifo1_almost_empty_n |-> cnt[0] > {1'b0, st.xo[0]})
		else $error("fifo1 almost-empty high at or below offset");
	chk_af_level: assert property (cnt[0] >= FULL_CNT - {1'b0, st.yo[0]} |-> !o_fifo1_almost_full_n)
		else $error("fifo1 almost-full high at threshold");
	chk_read_ptr: assert property (shift[0] |=> st.rd[0] == $past(st.rd[0]) + PTR_ONE)
		else $error("fifo1 read pointer did not step on load");
	chk_ef_two_edges: assert property ($rose(st.st2[`F_EF]) |-> $past(edg[1]) && $past(st.st1[`F_EF]))
		else $error("fifo1 empty flag rose without two port b edges");

	// level checks for the full flags and the fifo2 thresholds
	chk_f1_full_level: assert property (cnt[0] == FULL_CNT |-> !o_fifo1_full_or_in_ready)
		else $error("fifo1 full flag high at full depth");
	chk_f2_full_level: assert property (cnt[1] == FULL_CNT |-> !o_fifo2_full_or_in_ready)
		else $error("fifo2 full flag high at full depth");
	chk_f2_ae_level: assert property (o_fifo2_almost_empty_n |-> cnt[1] > {1'b0, st.xo[1]})
		else $error("fifo2 almost-empty high at or below offset");
	chk_f2_af_level: assert property (cnt[1] >= FULL_CNT - {1'b0, st.yo[1]} |-> !o_fifo2_almost_full_n)
		else $error("fifo2 almost-full high at threshold");

	// output register and read side behaviour
	chk_first_word_fall_through_load: assert property (first_word_fall_through && shift[0] |=> st.ov[0])
		else $error("first_word_fall_through load did not set output ready");
	chk_std_no_valid: assert property (!first_word_fall_through |=> !st.ov[0])
		else $error("output valid set in standard mode");
	chk_read_ignored: assert property (rd_att[0] && !rdy_out[0] && !first_word_fall_through |=> $stable(o_port_b_data))
		else $error("port b word changed on an ignored read");
	chk_f2_read_ptr: assert property (shift[1] |=> st.rd[1] == $past(st.rd[1]) + PTR_ONE)
		else $error("fifo2 read pointer did not step on load");

	// loopback, port a drive and port c buffer room
	chk_loop_full_hold: assert property (loop && !f1_wok |-> !we[0])
		else $error("loop wrote fifo1 while full");
	chk_normal_hiz: assert property (mode == fifo_flags_pkg::PA_NORMAL && (!a_cs || a_dir) |=> o_port_a_data_oe_n)
		else $error("port a driven outside a normal read");
	chk_buf_room: assert property (c_acc |-> st.bcnt != BUF_FULL)
		else $error("port c word taken with buffer full");

	cov_loop_full_read: cover property (loop && !a_dir && rd_ok[1] && !f1_wok);
	cov_loop_last_word: cover property (loop && we[0] && !rdy_out[1]);
	cov_first_word_fall_through_shift: cover property (first_word_fall_through && shift[0] && !st.ov[0]);
	cov_buf_full: cover property (!buf_rdy);
	cov_loop_write: cover property (we[0] && loop);

endmodule : dual_fifo_flags_loopback
`default_nettype wire

// File: logic/fifo_flags_map.svh
// constants for the dual fifo flag and loopback block
`ifndef FIFO_FLAGS_MAP_SVH
`define FIFO_FLAGS_MAP_SVH

// default geometry
`define DEPTH_DEF     2048
`define DATA_W_DEF    36
`define BUF_DEPTH_DEF 2

// control pin positions above the two data fields of the pin vector
`define P_PORT_A_CLOCK  0
`define P_PORT_B_CLOCK  1
`define P_PORT_C_CLOCK  2
`define P_A_CSN 3
`define P_A_DIR 4
`define P_A_EN  5
`define P_A_MB  6
`define P_LOOPN 7
`define P_B_CSN 8
`define P_B_REN 9
`define P_B_MB  10
`define P_C_WEN 11
`define P_C_MB  12
`define P_NUM   13

// flag slots per fifo; fifo2 sits one stride above fifo1
`define F_EF      0
`define F_AE      1
`define F_FF      2
`define F_AF      3
`define F_STRIDE  4
`define NUM_FLAGS 8

// sync stages after reset: full and almost-full good, others not
`define FLAG_RST 8'hCC

`endif

// File: logic/fifo_flags_pkg.sv
// shared types for the dual fifo flag and loopback block
package fifo_flags_pkg;

	// port a operating manner, one-hot
	typedef enum logic [2:0] {
		PA_NORMAL  = 3'h1,
		PA_LOOP_WR = 3'h2,
		PA_LOOP_RD = 3'h4
	} port_a_mode_t;

endpackage : fifo_flags_pkg
